// [hdl/strap_sync.sv]
// package of strap decoder constants and the strap pin synchroniser
`timescale 1ns/100ps
package strap_cfg_pkg;
   // register indices on the serial side
   localparam logic [2:0] REG_TMDS = 3'h0;
   localparam logic [2:0] REG_AUX = 3'h1;
   localparam logic [2:0] REG_RX = 3'h2;
   localparam logic [2:0] REG_PULSE_AB = 3'h3;
   localparam logic [2:0] REG_PULSE_CD = 3'h4;
   localparam logic [2:0] REG_EQ_AB = 3'h5;
   localparam logic [2:0] REG_EQ_CD = 3'h6;
   localparam logic [2:0] REG_TX = 3'h7;
   localparam int REG_COUNT = 8;
   // field positions
   localparam int POS_ENABLE = 6;
   localparam int POS_MODE_LO = 4;
   localparam int POS_SRC_LO = 0;
   localparam int POS_IN_TERM = 0;
   localparam int POS_PE_LO = 2;
   localparam int POS_OUT_TERM = 1;
   localparam int POS_OUT_CUR = 0;
   // field values
   localparam logic [1:0] MODE_QUAD = 2'h0;
   localparam logic AUX_ON = 1'b1;
   localparam logic IN_TERM_ON = 1'b1;
   localparam logic [7:0] PULSE_OFF = 8'h00;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   // equalizer levels in dB
   localparam int EQ_LOW_DB = 6;
   localparam int EQ_HIGH_DB = 12;
   // output current in mA
   localparam int CUR_LOW_MA = 10;
   localparam int CUR_HIGH_MA = 20;
   // pre-emphasis codes
   localparam logic [1:0] PE_NONE = 2'h0;
   localparam logic [1:0] PE_LOW = 2'h1;
   localparam logic [1:0] PE_MED = 2'h2;
   localparam logic [1:0] PE_HIGH = 2'h3;

   // strap pins as one bundle
   typedef struct packed {
      logic channel_enable;
      logic [1:0] source_select;
      logic equalization_level;
      logic [1:0] preemphasis_level;
      logic output_termination;
      logic output_current;
   } strap_t;
   localparam int STRAP_W = $bits(strap_t);
endpackage

module strap_sync #(
   parameter int WIDTH = 8
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [WIDTH-1:0] raw_i,
   output logic [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   // two flops, the first read only by the second
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= raw_i;
         sync_q <= meta_q;
      end
   end

   assign sync_o = sync_q;
endmodule

// [hdl/strap_pin_config_decoder.sv]
// strap pin configuration decoder with serial-side register file
`timescale 1ns/100ps
module strap_pin_config_decoder
   import strap_cfg_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   // raw strap pins
   input wire logic strap_channel_enable_i,
   input wire logic [1:0] strap_source_select_i,
   input wire logic strap_equalization_level_i,
   input wire logic [1:0] strap_preemphasis_level_i,
   input wire logic strap_output_termination_i,
   input wire logic strap_output_current_i,
   // register port from the serial control engine
   input wire logic host_wr_i,
   input wire logic host_rd_i,
   input wire logic [2:0] host_addr_i,
   input wire logic [7:0] host_wdata_i,
   output logic [7:0] host_rdata_o,
   output logic host_rvalid_o,
   // configuration as seen by the analog core
   output logic strap_active_o,
   output logic tmds_enable_o,
   output logic [1:0] tmds_mode_o,
   output logic [1:0] tmds_source_o,
   output logic aux_enable_o,
   output logic [1:0] aux_mode_o,
   output logic [1:0] common_aux_port_source_o,
   output logic input_termination_o,
   output logic [7:0] pulse_ab_o,
   output logic [7:0] pulse_cd_o,
   output logic [7:0] eq_ab_o,
   output logic [7:0] eq_cd_o,
   output logic eq_high_o,
   output logic [1:0] preemphasis_o,
   output logic output_termination_o,
   output logic output_current_high_o
);

   // image of one register as the straps define it
   function automatic logic [7:0] strap_image(input strap_t s, input logic [2:0] idx);
      logic [7:0] b;
      // bits that neither a strap nor a fixed value (aux enable, input termination) drives stay zero
      b = 8'h00;
      case (idx)
         REG_TMDS: begin
            b[POS_ENABLE] = s.channel_enable;
            b[POS_MODE_LO +: 2] = MODE_QUAD;
            b[POS_SRC_LO +: 2] = s.source_select;
         end
         REG_AUX: begin
            b[POS_ENABLE] = AUX_ON;
            b[POS_MODE_LO +: 2] = MODE_QUAD;
            b[POS_SRC_LO +: 2] = s.source_select;
         end
         REG_RX: b[POS_IN_TERM] = IN_TERM_ON;
         REG_PULSE_AB: b = PULSE_OFF;
         REG_PULSE_CD: b = PULSE_OFF;
         REG_EQ_AB: b = {8{s.equalization_level}};
         REG_EQ_CD: b = {8{s.equalization_level}};
         REG_TX: begin
            b[POS_PE_LO +: 2] = s.preemphasis_level;
            b[POS_OUT_TERM] = s.output_termination;
            b[POS_OUT_CUR] = s.output_current;
         end
         default: b = RESET_BYTE;
      endcase
      return b;
   endfunction

   // bundles, strap-path state and the register file
   strap_t strap_raw;
   strap_t strap_s;
   logic strap_active_q;
   logic strap_active_d;
   logic [7:0] cfg_q [REG_COUNT];
   logic [7:0] cfg_d [REG_COUNT];
   logic [7:0] rdata_q;
   logic rvalid_q;
   wire host_access = host_wr_i | host_rd_i;

   // gather pins into one bundle
   assign strap_raw.channel_enable = strap_channel_enable_i;
   assign strap_raw.source_select = strap_source_select_i;
   assign strap_raw.equalization_level = strap_equalization_level_i;
   assign strap_raw.preemphasis_level = strap_preemphasis_level_i;
   assign strap_raw.output_termination = strap_output_termination_i;
   assign strap_raw.output_current = strap_output_current_i;

   // pins are asynchronous to the core clock
   strap_sync #(
      .WIDTH(STRAP_W)
   ) u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .raw_i(strap_raw),
      .sync_o(strap_s)
   );

   // one-hot register hit of a strobe
   function automatic logic [REG_COUNT-1:0] index_hit(input logic hit, input logic [2:0] idx);
      logic [REG_COUNT-1:0] h;
      h = '0;
      h[idx] = hit;
      return h;
   endfunction

   // write decode, one bit per register
   wire [REG_COUNT-1:0] wr_hit = index_hit(host_wr_i, host_addr_i);

   // strap path lasts until the first serial access
   // a read counts too; the host then sees the last strap image
   assign strap_active_d = strap_active_q & ~host_access;

   // next register values: straps while active, else held; a serial write overrides either
   always_comb begin
      for (int i = 0; i < REG_COUNT; i++) begin
         if (strap_active_q) begin
            cfg_d[i] = strap_image(strap_s, 3'(i));
         end else begin
            cfg_d[i] = cfg_q[i];
         end
         if (wr_hit[i]) begin
            cfg_d[i] = host_wdata_i;
         end
      end
   end

   // register file and strap-path state
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         strap_active_q <= 1'b1;
         for (int i = 0; i < REG_COUNT; i++) begin
            cfg_q[i] <= strap_image(strap_t'('0), 3'(i));
         end
      end else begin
         strap_active_q <= strap_active_d;
         for (int i = 0; i < REG_COUNT; i++) begin
            cfg_q[i] <= cfg_d[i];
         end
      end
   end

   // read data returned one cycle after the strobe
   // a read beside a write in one cycle returns the old value
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_q <= 8'h00;
         rvalid_q <= 1'b0;
      end else begin
         rvalid_q <= host_rd_i;
         if (host_rd_i) begin
            rdata_q <= cfg_q[host_addr_i];
         end
      end
   end

   // outputs are bits of the flops above
   assign host_rdata_o = rdata_q;
   assign host_rvalid_o = rvalid_q;
   assign strap_active_o = strap_active_q;
   assign tmds_enable_o = cfg_q[REG_TMDS][POS_ENABLE];
   assign tmds_mode_o = cfg_q[REG_TMDS][POS_MODE_LO +: 2];
   assign tmds_source_o = cfg_q[REG_TMDS][POS_SRC_LO +: 2];
   assign aux_enable_o = cfg_q[REG_AUX][POS_ENABLE];
   assign aux_mode_o = cfg_q[REG_AUX][POS_MODE_LO +: 2];
   assign common_aux_port_source_o = cfg_q[REG_AUX][POS_SRC_LO +: 2];
   assign input_termination_o = cfg_q[REG_RX][POS_IN_TERM];
   assign pulse_ab_o = cfg_q[REG_PULSE_AB];
   assign pulse_cd_o = cfg_q[REG_PULSE_CD];
   assign eq_ab_o = cfg_q[REG_EQ_AB];
   assign eq_cd_o = cfg_q[REG_EQ_CD];
   // bit 0 of the first equalizer register picks the high level (12 dB)
   assign eq_high_o = cfg_q[REG_EQ_AB][0];
   assign preemphasis_o = cfg_q[REG_TX][POS_PE_LO +: 2];
   assign output_termination_o = cfg_q[REG_TX][POS_OUT_TERM];
   assign output_current_high_o = cfg_q[REG_TX][POS_OUT_CUR];

   // checks on the decoded configuration
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   // a cycle that carried strap values forward, tracked in flops
   logic strap_prev_q;
   logic step_d1_q;
   logic step_d2_q;
   wire strap_step = strap_active_q & strap_prev_q;
   // strap path unbroken across both sync stages and the register
   wire pin_path_full = strap_step & step_d1_q & step_d2_q;
   // history for the checks below
   always_ff @(posedge clk_i) begin
      strap_prev_q <= strap_active_q & ~rst_i;
      step_d1_q <= strap_step;
      step_d2_q <= step_d1_q;
   end

   a_quad_forced: assert property (strap_active_q |-> tmds_mode_o == MODE_QUAD)
      else $error("high-speed mode not quad under straps");

   a_channel_enable: assert property (
      strap_step |-> tmds_enable_o == $past(strap_s.channel_enable))
      else $error("channel enable does not follow strap");

   a_tmds_source: assert property (
      strap_step |-> tmds_source_o == $past(strap_s.source_select))
      else $error("high-speed source does not follow strap");

   a_aux_quad_on: assert property (
      strap_active_q |-> aux_enable_o && aux_mode_o == MODE_QUAD)
      else $error("aux switch not enabled quad under straps");

   a_aux_source: assert property (
      strap_active_q |-> common_aux_port_source_o == tmds_source_o)
      else $error("aux source differs from high-speed source");

   a_in_term_on: assert property (strap_active_q |-> input_termination_o)
      else $error("input termination off under straps");

   a_pulse_off: assert property (
      strap_active_q |-> pulse_ab_o == PULSE_OFF && pulse_cd_o == PULSE_OFF)
      else $error("pulse-on-switch enabled under straps");

   a_eq_replicate: assert property (
      strap_step |-> eq_ab_o == {8{$past(strap_s.equalization_level)}}
         && eq_cd_o == eq_ab_o)
      else $error("equalizer bits not replicated");

   a_eq_level: assert property (
      strap_step |-> eq_high_o == $past(strap_s.equalization_level))
      else $error("equalization level does not follow strap");

   a_preemph: assert property (
      strap_step |-> preemphasis_o == $past(strap_s.preemphasis_level))
      else $error("pre-emphasis does not follow strap");

   a_out_term: assert property (
      strap_step |-> output_termination_o == $past(strap_s.output_termination))
      else $error("output termination does not follow strap");

   a_out_current: assert property (
      strap_step |-> output_current_high_o == $past(strap_s.output_current))
      else $error("output current does not follow strap");

   a_term_write: assert property (
      host_wr_i && host_addr_i == REG_RX |=> input_termination_o == $past(host_wdata_i[0]))
      else $error("input termination write not applied");

   a_strap_ends: assert property (
      host_access |=> !strap_active_q [*3])
      else $error("strap path alive after serial access");

   a_strap_frozen: assert property (
      !strap_active_q && !host_wr_i |=> $stable(tmds_source_o) && $stable(eq_ab_o))
      else $error("strap change reached registers after access");

   a_fixed_bits: assert property (
      strap_active_q |-> cfg_q[REG_TMDS][3:2] == 2'h0 && cfg_q[REG_RX][7:1] == 7'h00
         && cfg_q[REG_TX][7:4] == 4'h0 && cfg_q[REG_AUX][7] == 1'b0)
      else $error("undriven bits not constant under straps");

   a_read_data: assert property (
      host_rd_i |=> host_rvalid_o && host_rdata_o == $past(cfg_q[host_addr_i]))
      else $error("read data wrong or late");

   // read valid only ever answers a strobe
   a_rvalid_cause: assert property (host_rvalid_o |-> $past(host_rd_i))
      else $error("read valid without a read strobe");

   // read valid stands for one cycle
   a_rvalid_single: assert property (host_rvalid_o && !host_rd_i |=> !host_rvalid_o)
      else $error("read valid longer than one cycle");

   // read data holds until the next read
   a_rdata_hold: assert property (!host_rd_i |=> $stable(host_rdata_o))
      else $error("read data changed without a read");

   // every serial write lands in its register
   a_write_lands: assert property (
      host_wr_i |=> cfg_q[$past(host_addr_i)] == $past(host_wdata_i))
      else $error("serial write not stored");

   // output termination switched on its own from the serial side
   a_out_term_write: assert property (
      host_wr_i && host_addr_i == REG_TX
         |=> output_termination_o == $past(host_wdata_i[POS_OUT_TERM]))
      else $error("output termination write not applied");

   // only a reset brings the straps back
   a_strap_stays_off: assert property (!strap_active_q |=> !strap_active_q)
      else $error("strap path came back without reset");

   // reset loads the image of all-zero straps
   a_reset_image: assert property (
      $past(rst_i) |-> strap_active_q && !tmds_enable_o && aux_enable_o
         && input_termination_o && eq_ab_o == 8'h00 && preemphasis_o == PE_NONE)
      else $error("reset image of registers wrong");

   // transmitter and aux settings frozen once the host owns them
   a_tx_frozen: assert property (
      !strap_active_q && !host_wr_i |=> $stable(preemphasis_o) && $stable(tmds_enable_o)
         && $stable(output_current_high_o) && $stable(common_aux_port_source_o))
      else $error("strap change reached outputs after access");

   // pins reach the registers through both sync stages, no sooner
   a_src_latency: assert property (
      pin_path_full |-> tmds_source_o == $past(strap_source_select_i, 3)
         && common_aux_port_source_o == $past(strap_source_select_i, 3))
      else $error("source strap latency wrong");

   // standby follows the enable pin with the same latency
   a_enable_latency: assert property (
      pin_path_full |-> tmds_enable_o == $past(strap_channel_enable_i, 3))
      else $error("channel enable strap latency wrong");

   // equalization pin latency
   a_eq_latency: assert property (
      pin_path_full |-> eq_high_o == $past(strap_equalization_level_i, 3))
      else $error("equalization strap latency wrong");

   // transmitter pins latency
   a_tx_latency: assert property (
      pin_path_full |-> preemphasis_o == $past(strap_preemphasis_level_i, 3)
         && output_termination_o == $past(strap_output_termination_i, 3)
         && output_current_high_o == $past(strap_output_current_i, 3))
      else $error("transmitter strap latency wrong");

endmodule

// [verif/strap_board.sv]
// board strap pins as seen by the decoder, loaded by the bench
`timescale 1ns/100ps
module strap_board
   import strap_cfg_pkg::*;
#(
   parameter logic DEFAULT_EQ = 1'b1 // high level suits nearly all cables
) (
   input wire logic clk_i,
   input wire logic load_i,
   input wire strap_t cfg_i,
   output strap_t pins_o
);
   strap_t pins_q = '{default: 1'b0, equalization_level: DEFAULT_EQ};
   // straps are static levels, changed only when the bench reloads them
   always_ff @(posedge clk_i) begin
      if (load_i) begin
         pins_q <= cfg_i;
      end
   end
   assign pins_o = pins_q;
endmodule

// [verif/tb_top.sv]
// self-checking bench for the strap configuration decoder
`timescale 1ns/100ps
module tb_top;
   import strap_cfg_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic load = 1'b0;
   strap_t cfg = '0;
   strap_t pins;
   logic host_wr = 1'b0;
   logic host_rd = 1'b0;
   logic [2:0] host_addr = 3'h0;
   logic [7:0] host_wdata = 8'h00;
   logic [7:0] rdata;
   logic rvalid, act, t_en, a_en, in_t, eq_hi, o_t, o_c;
   logic [1:0] t_mode, t_src, a_mode, a_src, pe;
   logic [7:0] p_ab, p_cd, e_ab, e_cd, d;
   int error_cnt = 0;
   int comparisons = 0;
   strap_t tbl [4] = '{8'h82, 8'h35, 8'hC9, 8'hFE};

   strap_board u_board (.clk_i(clk_i), .load_i(load), .cfg_i(cfg), .pins_o(pins));
   strap_pin_config_decoder u_dut (.clk_i(clk_i), .rst_i(rst_i),
      .strap_channel_enable_i(pins.channel_enable), .strap_source_select_i(pins.source_select),
      .strap_equalization_level_i(pins.equalization_level),
      .strap_preemphasis_level_i(pins.preemphasis_level),
      .strap_output_termination_i(pins.output_termination),
      .strap_output_current_i(pins.output_current), .host_wr_i(host_wr), .host_rd_i(host_rd),
      .host_addr_i(host_addr), .host_wdata_i(host_wdata), .host_rdata_o(rdata),
      .host_rvalid_o(rvalid), .strap_active_o(act), .tmds_enable_o(t_en), .tmds_mode_o(t_mode),
      .tmds_source_o(t_src), .aux_enable_o(a_en), .aux_mode_o(a_mode),
      .common_aux_port_source_o(a_src), .input_termination_o(in_t), .pulse_ab_o(p_ab),
      .pulse_cd_o(p_cd), .eq_ab_o(e_ab), .eq_cd_o(e_cd), .eq_high_o(eq_hi),
      .preemphasis_o(pe), .output_termination_o(o_t), .output_current_high_o(o_c));

   // 50 MHz clock
   initial begin
      forever #10 clk_i = ~clk_i;
   end

   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // register image that a given strap setting should produce
   function automatic logic [7:0] img(input strap_t s, input logic [2:0] i);
      case (i)
         REG_TMDS: img = {1'b0, s.channel_enable, MODE_QUAD, 2'h0, s.source_select};
         REG_AUX: img = {1'b0, AUX_ON, MODE_QUAD, 2'h0, s.source_select};
         REG_RX: img = {7'h00, IN_TERM_ON};
         REG_EQ_AB, REG_EQ_CD: img = {8{s.equalization_level}};
         REG_TX: img = {4'h0, s.preemphasis_level, s.output_termination, s.output_current};
         default: img = PULSE_OFF;
      endcase
   endfunction

   task automatic set_straps(input strap_t s);
      @(posedge clk_i);
      load <= 1'b1;
      cfg <= s;
      @(posedge clk_i);
      load <= 1'b0;
      repeat (4) @(posedge clk_i);
      #1;
   endtask

   task automatic check_outs(input strap_t s);
      chk("tmds_mode", 8'(t_mode), 8'(MODE_QUAD));
      chk("tmds_enable", 8'(t_en), 8'(s.channel_enable));
      chk("tmds_source", 8'(t_src), 8'(s.source_select));
      chk("aux_cfg", {5'h00, a_en, a_mode}, {5'h00, AUX_ON, MODE_QUAD});
      chk("aux_source", 8'(a_src), 8'(s.source_select));
      chk("in_term", 8'(in_t), 8'(IN_TERM_ON));
      chk("pulse", p_ab | p_cd, PULSE_OFF);
      chk("eq_ab", e_ab, {8{s.equalization_level}});
      chk("eq_cd", e_cd, {8{s.equalization_level}});
      chk("eq_high", 8'(eq_hi), 8'(s.equalization_level));
      chk("preemph", 8'(pe), 8'(s.preemphasis_level));
      chk("out_term", 8'(o_t), 8'(s.output_termination));
      chk("out_cur", 8'(o_c), 8'(s.output_current));
      chk("strap_active", 8'(act), 8'h01);
   endtask

   task automatic wr(input logic [2:0] a, input logic [7:0] v);
      @(posedge clk_i);
      host_wr <= 1'b1;
      host_addr <= a;
      host_wdata <= v;
      @(posedge clk_i);
      host_wr <= 1'b0;
      @(posedge clk_i);
      #1;
   endtask

   task automatic rd(input logic [2:0] a, output logic [7:0] v);
      @(posedge clk_i);
      host_rd <= 1'b1;
      host_addr <= a;
      @(posedge clk_i);
      host_rd <= 1'b0;
      #1;
      chk("rvalid", 8'(rvalid), 8'h01);
      v = rdata;
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // watchdog against a hung run
   initial begin
      repeat (5000) @(posedge clk_i);
      error_cnt++;
      wrap_up();
   end

   // main sequence
   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      foreach (tbl[i]) begin
         set_straps(tbl[i]);
         check_outs(tbl[i]);
      end
      // first access ends the strap path, reads return the last image
      for (int i = 0; i < REG_COUNT; i++) begin
         rd(3'(i), d);
         chk("strap_image", d, img(tbl[3], 3'(i)));
      end
      chk("strap_active", 8'(act), 8'h00);
      set_straps(tbl[0]);
      chk("frozen_source", 8'(t_src), 8'h03);
      // terminations switched one at a time from the serial side
      wr(REG_RX, 8'h00);
      chk("in_term_off", {in_t, 6'h00, o_t}, 8'h01);
      wr(REG_TX, 8'h0C);
      chk("out_term_off", {in_t, 6'h00, o_t}, 8'h00);
      wr(REG_RX, 8'h01);
      chk("in_term_on", {in_t, 6'h00, o_t}, 8'h80);
      for (int i = 0; i < REG_COUNT; i++) begin
         wr(3'(i), 8'hA5 ^ 8'(i));
         rd(3'(i), d);
         chk("readback", d, 8'hA5 ^ 8'(i));
      end
      // a second reset brings the straps back in charge
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      set_straps(tbl[1]);
      check_outs(tbl[1]);
      // a write as first access lands, other registers keep the strap image
      wr(REG_TX, 8'h03);
      chk("first_write", {act, 5'h00, o_t, o_c}, 8'h03);
      rd(REG_TMDS, d);
      chk("kept_image", d, img(tbl[1], REG_TMDS));
      wrap_up();
   end
endmodule
